// ===== shared/epe_pkg.sv
package epe_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int ARRAY_BYTES   = 128;
    localparam int ADDR_W        = 7;
    localparam int BLOCK_BYTES   = 32;
    localparam int BLOCK_SHIFT   = 5;
    localparam int DATA_W        = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ----------------------------------------------------------------
    // Control register bit positions and reset value
    // ----------------------------------------------------------------
    localparam int BIT_PGM   = 0;
    localparam int BIT_RC    = 1;
    localparam int BIT_LATCH = 2;
    localparam int BIT_ERLO  = 3;
    localparam int BIT_ERHI  = 4;
    localparam int BIT_PUMP  = 6;
    localparam int BIT_LVI   = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Timing, informative for software only
    // ----------------------------------------------------------------
    localparam real RC_SWITCH_MHZ = 1.5;
    localparam real MCLK_MHZ      = 250.0;
    // Software waits in mclk cycles; plain defaults, real pulses are far longer
    localparam int RC_STARTUP_TIME   = 16;
    localparam int BYTE_PROGRAM_TIME = 20;
    localparam int BYTE_ERASE_TIME   = 20;
    localparam int BLOCK_ERASE_TIME  = 40;
    localparam int BULK_ERASE_TIME   = 60;
    localparam int VOLTAGE_FALL_TIME = 8;

    typedef enum logic [1:0] {
        EPE_MODE_PROGRAM,
        EPE_MODE_BYTE_ERASE,
        EPE_MODE_BLOCK_ERASE,
        EPE_MODE_BULK_ERASE
    } epe_mode_e;

    typedef enum {
        EPE_IDLE,
        EPE_ARMED,
        EPE_PULSE
    } epe_state_e;

    // Control bits as software sees them
    typedef struct packed {
        logic lvi;
        logic pump_en;
        logic rsvd;
        logic er_hi;
        logic er_lo;
        logic latch;
        logic rc_sel;
        logic pgm;
    } epe_ctrl_s;

    // One CPU access to the array region
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } epe_acc_s;

endpackage

// ===== verilog/epe_sync3.sv
`timescale 1ns/100ps
module epe_sync3
    import epe_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    // ----------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ----------------------------------------------------------------
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q     <= 1'b0;
            s2_q     <= 1'b0;
            s3_q     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_out <= s3_q;
            end
        end
    end
endmodule

// ===== verilog/epe_ctrl.sv
`timescale 1ns/100ps
module epe_ctrl
    import epe_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              rc_clk,
    input  wire logic              low_voltage_pin,
    input  wire logic              ctrl_wr,
    input  wire logic [7:0]        ctrl_wdata,
    output logic      [7:0]        ctrl_rdata,
    input  wire epe_acc_s          acc,
    output logic      [DATA_W-1:0] arr_rdata,
    output logic                   arr_rd_blocked,
    output logic                   pump_on,
    output logic                   program_power_active,
    output logic                   timing_clk_rc,
    output logic                   timing_clk
);
    // ----------------------------------------------------------------
    // Storage and control state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [ARRAY_BYTES];
    epe_ctrl_s         ctrl_q;
    epe_ctrl_s         ctrl_d;
    epe_ctrl_s         wr_v;
    logic              low_voltage_inhibit_flag;
    logic [ADDR_W-1:0] cap_addr_q;
    logic [DATA_W-1:0] cap_data_q;
    logic              cap_valid_q;
    logic              pgm_prev_q;
    logic [DATA_W-1:0] rdata_q;

    epe_sync3 u_lvi_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (low_voltage_pin),
        .sync_out (low_voltage_inhibit_flag)
    );

    // ----------------------------------------------------------------
    // Control register next value
    // ----------------------------------------------------------------
    assign wr_v = epe_ctrl_s'(ctrl_wdata);

    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d.latch  = wr_v.latch;
            ctrl_d.rc_sel = wr_v.rc_sel;
            ctrl_d.er_hi  = wr_v.er_hi;
            ctrl_d.er_lo  = wr_v.er_lo;
            ctrl_d.pump_en = wr_v.pump_en;
            if (ctrl_q.latch) begin
                ctrl_d.pgm = wr_v.pgm;
            end else begin
                ctrl_d.pgm = 1'b0;
            end
        end
        if (low_voltage_inhibit_flag) begin
            // Inhibit clears bits 0..6 and blocks any write setting them
            ctrl_d.latch  = 1'b0;
            ctrl_d.rc_sel = 1'b0;
            ctrl_d.pgm    = 1'b0;
            ctrl_d.pump_en = 1'b0;
            ctrl_d.er_hi  = 1'b0;
            ctrl_d.er_lo  = 1'b0;
        end
        ctrl_d.rsvd = 1'b0;
        ctrl_d.lvi  = low_voltage_inhibit_flag;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= epe_ctrl_s'(CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl_rdata = ctrl_q;

    // ----------------------------------------------------------------
    // Clock source and power status
    // ----------------------------------------------------------------
    // Plain mux: software must wait RC start-up before relying on it
    assign timing_clk_rc        = ctrl_q.rc_sel;
    assign timing_clk           = ctrl_q.rc_sel ? rc_clk : mclk;
    assign pump_on              = ctrl_q.pgm | ctrl_q.pump_en;
    assign program_power_active = ctrl_q.pgm;

    // ----------------------------------------------------------------
    // Capture of array writes
    // ----------------------------------------------------------------
    wire cap_write = acc.wr & ctrl_q.latch;
    wire pgm_rise  = ctrl_q.pgm & ~pgm_prev_q;
    wire act_go    = pgm_rise & cap_valid_q;
    wire [1:0] mode_w = {ctrl_q.er_hi, ctrl_q.er_lo};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cap_addr_q  <= '0;
            cap_data_q  <= '0;
            cap_valid_q <= 1'b0;
            pgm_prev_q  <= 1'b0;
        end else begin
            pgm_prev_q <= ctrl_q.pgm;
            if (cap_write) begin
                cap_addr_q  <= acc.addr;
                cap_data_q  <= acc.wdata;
                cap_valid_q <= 1'b1;
            end else if (!ctrl_q.latch) begin
                cap_valid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Array: one action at the rising edge of programming power
    // ----------------------------------------------------------------
    // Without analog cells the pulse length is not modelled; the effect
    // lands when power comes on and software owns the duration.
    genvar gi;
    generate
        for (gi = 0; gi < ARRAY_BYTES; gi++) begin : g_cell
            localparam logic [ADDR_W-1:0] CELL_ADDR = ADDR_W'(gi);
            wire in_blk = (cap_addr_q[ADDR_W-1:BLOCK_SHIFT] ==
                           CELL_ADDR[ADDR_W-1:BLOCK_SHIFT]);
            wire hit    = (cap_addr_q == CELL_ADDR);
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    mem_q[gi] <= ERASED_BYTE;
                end else if (act_go) begin
                    case (epe_mode_e'(mode_w))
                        EPE_MODE_PROGRAM: begin
                            if (hit) begin
                                mem_q[gi] <= mem_q[gi] & cap_data_q;
                            end
                        end
                        EPE_MODE_BYTE_ERASE: begin
                            if (hit) begin
                                mem_q[gi] <= ERASED_BYTE;
                            end
                        end
                        EPE_MODE_BLOCK_ERASE: begin
                            if (in_blk) begin
                                mem_q[gi] <= ERASED_BYTE;
                            end
                        end
                        EPE_MODE_BULK_ERASE: begin
                            mem_q[gi] <= ERASED_BYTE;
                        end
                        default: begin
                            mem_q[gi] <= mem_q[gi];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Reads
    // ----------------------------------------------------------------
    assign arr_rd_blocked = ctrl_q.latch & cap_valid_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (acc.rd) begin
            rdata_q <= arr_rd_blocked ? '0 : mem_q[acc.addr];
        end
    end
    assign arr_rdata = rdata_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_PGM_NEEDS_LATCH: assert property (@(posedge mclk) disable iff (rst)
        ctrl_q.pgm |-> $past(ctrl_q.latch))
        else $error("power bit set without prior capture");
    AST_NO_DOUBLE_SET: assert property (@(posedge mclk) disable iff (rst)
        (ctrl_wr && !ctrl_q.latch) |=> !ctrl_q.pgm)
        else $error("capture and power set by one write");
    AST_LVI_CLEARS: assert property (@(posedge mclk) disable iff (rst)
        low_voltage_inhibit_flag |=> (ctrl_q[6:0] == 7'h00))
        else $error("inhibit did not clear control bits");
    AST_RC_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        low_voltage_inhibit_flag |=> !timing_clk_rc)
        else $error("clock select survived inhibit");
    AST_PWR_STATUS: assert property (@(posedge mclk) disable iff (rst)
        $changed(program_power_active) |-> $past(ctrl_wr || low_voltage_inhibit_flag))
        else $error("power status moved without a write or inhibit");
    AST_CAPTURE: assert property (@(posedge mclk) disable iff (rst)
        cap_write |=> (cap_addr_q == $past(acc.addr)) && arr_rd_blocked)
        else $error("write in capture mode not latched");
    AST_NO_CAPTURE: assert property (@(posedge mclk) disable iff (rst)
        (acc.wr && !ctrl_q.latch) |=> $stable(cap_data_q))
        else $error("latch changed while capture clear");
    AST_PUMP_LVI: assert property (@(posedge mclk) disable iff (rst)
        (low_voltage_inhibit_flag && ctrl_wr && ctrl_wdata[BIT_PUMP]) |=> !ctrl_q.pump_en)
        else $error("pump enable set during inhibit");
    COV_PROGRAM: cover property (@(posedge mclk) disable iff (rst)
        act_go && mode_w == 2'h0);
    COV_BLOCK: cover property (@(posedge mclk) disable iff (rst)
        act_go && mode_w == 2'h2);
    COV_LVI_ABORT: cover property (@(posedge mclk) disable iff (rst)
        ctrl_q.pgm ##1 low_voltage_inhibit_flag);
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import epe_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                mclk;
    logic                rst;
    logic                rc_clk;
    logic                low_voltage_pin;
    logic                ctrl_wr;
    logic [7:0]          ctrl_wdata;
    logic [7:0]          ctrl_rdata;
    epe_acc_s            acc;
    logic [DATA_W-1:0]   arr_rdata;
    logic                arr_rd_blocked;
    logic                pump_on;
    logic                program_power_active;
    logic                timing_clk_rc;
    logic                timing_clk;
    int                  mismatches;
    int                  n_tests;

    epe_ctrl u_epe_ctrl (
        .mclk                 (mclk),
        .rst                  (rst),
        .rc_clk               (rc_clk),
        .low_voltage_pin      (low_voltage_pin),
        .ctrl_wr              (ctrl_wr),
        .ctrl_wdata           (ctrl_wdata),
        .ctrl_rdata           (ctrl_rdata),
        .acc                  (acc),
        .arr_rdata            (arr_rdata),
        .arr_rd_blocked       (arr_rd_blocked),
        .pump_on              (pump_on),
        .program_power_active (program_power_active),
        .timing_clk_rc        (timing_clk_rc),
        .timing_clk           (timing_clk)
    );

    always #2 mclk = ~mclk;

    // RC edges fall on odd tenths of a ns, so never race an mclk edge
    initial begin
        #0.1;
        forever #3.8 rc_clk = ~rc_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr_ctrl(input logic [7:0] d);
        ctrl_wdata = d;
        ctrl_wr    = 1'b1;
        @(negedge mclk);
        ctrl_wr    = 1'b0;
        @(negedge mclk);
    endtask

    task automatic acc_wr(input logic [6:0] a, input logic [7:0] d);
        acc.addr  = a;
        acc.wdata = d;
        acc.wr    = 1'b1;
        @(negedge mclk);
        acc.wr    = 1'b0;
        @(negedge mclk);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        acc.addr = a;
        acc.rd   = 1'b1;
        @(negedge mclk);
        acc.rd   = 1'b0;
        @(negedge mclk);
        chk("arr_rdata", e, arr_rdata);
    endtask

    // Full software sequence: setup, capture write, power pulse, teardown
    task automatic op(input logic [1:0] m, input logic [6:0] a, input logic [7:0] d);
        logic [7:0] c;
        int         n;
        c = 8'h44 | {3'h0, m, 3'h0};
        case (m)
            2'b00:   n = BYTE_PROGRAM_TIME;
            2'b01:   n = BYTE_ERASE_TIME;
            2'b10:   n = BLOCK_ERASE_TIME;
            default: n = BULK_ERASE_TIME;
        endcase
        wr_ctrl(c);
        acc_wr(a, d);
        wr_ctrl(c | 8'h01);
        repeat (n) @(negedge mclk);
        chk("power_active", 8'h01, {7'h00, program_power_active});
        wr_ctrl(c);
        repeat (VOLTAGE_FALL_TIME) @(negedge mclk);
        wr_ctrl(8'h00);
    endtask

    // Inhibit passes a synchroniser, so allow a bounded settling time
    task automatic wait_lvi(input logic v);
        int i;
        for (i = 0; i < 10 && ctrl_rdata[7] !== v; i++)
            @(negedge mclk);
        if (ctrl_rdata[7] !== v) begin
            mismatches++;
            $display("Error inhibit_flag expected %h seen %h", v, ctrl_rdata[7]);
            final_report();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("ctrl_rdata", 8'h00, ctrl_rdata);
        chk("pump_on", 8'h00, {7'h00, pump_on});
        rd_chk(7'h7f, ERASED_BYTE);
        $display("t_reset done");
    endtask

    task automatic t_power_gate;
        wr_ctrl(8'h01);
        chk("ctrl_rdata", 8'h00, ctrl_rdata);
        wr_ctrl(8'h45);
        chk("ctrl_rdata", 8'h44, ctrl_rdata);
        wr_ctrl(8'h45);
        chk("ctrl_rdata", 8'h45, ctrl_rdata);
        chk("power_active", 8'h01, {7'h00, program_power_active});
        chk("pump_on", 8'h01, {7'h00, pump_on});
        wr_ctrl(8'h44);
        chk("power_active", 8'h00, {7'h00, program_power_active});
        wr_ctrl(8'h00);
        chk("pump_on", 8'h00, {7'h00, pump_on});
        $display("t_power_gate done");
    endtask

    task automatic t_program;
        acc_wr(7'h05, 8'h00);
        rd_chk(7'h05, ERASED_BYTE);
        wr_ctrl(8'h44);
        acc_wr(7'h05, 8'h0f);
        chk("blocked", 8'h01, {7'h00, arr_rd_blocked});
        rd_chk(7'h05, 8'h00);
        wr_ctrl(8'h45);
        repeat (BYTE_PROGRAM_TIME) @(negedge mclk);
        wr_ctrl(8'h44);
        repeat (VOLTAGE_FALL_TIME) @(negedge mclk);
        wr_ctrl(8'h00);
        chk("blocked", 8'h00, {7'h00, arr_rd_blocked});
        rd_chk(7'h05, 8'h0f);
        op(2'b00, 7'h05, 8'h05);
        rd_chk(7'h05, 8'h05);
        op(2'b01, 7'h05, 8'h00);
        rd_chk(7'h05, ERASED_BYTE);
        $display("t_program done");
    endtask

    task automatic t_erase;
        op(2'b00, 7'h20, 8'h00);
        op(2'b00, 7'h3f, 8'h00);
        op(2'b00, 7'h40, 8'h00);
        op(2'b10, 7'h25, 8'h00);
        rd_chk(7'h20, ERASED_BYTE);
        rd_chk(7'h3f, ERASED_BYTE);
        rd_chk(7'h40, 8'h00);
        op(2'b11, 7'h00, 8'h00);
        rd_chk(7'h40, ERASED_BYTE);
        $display("t_erase done");
    endtask

    task automatic t_rc;
        wr_ctrl(8'h02);
        chk("rc_select", 8'h01, {7'h00, timing_clk_rc});
        repeat (RC_STARTUP_TIME) @(negedge mclk);
        repeat (4) begin
            @(negedge mclk);
            chk("timing_clk", {7'h00, rc_clk}, {7'h00, timing_clk});
        end
        wr_ctrl(8'h00);
        // Look away from the mclk edge so the mux output has settled
        #1;
        chk("timing_clk", {7'h00, mclk}, {7'h00, timing_clk});
        #2;
        chk("timing_clk", {7'h00, mclk}, {7'h00, timing_clk});
        @(negedge mclk);
        $display("t_rc done");
    endtask

    task automatic t_inhibit;
        wr_ctrl(8'h5e);
        wr_ctrl(8'h5f);
        chk("ctrl_rdata", 8'h5f, ctrl_rdata);
        low_voltage_pin = 1'b1;
        wait_lvi(1'b1);
        @(negedge mclk);
        chk("ctrl_rdata", 8'h80, ctrl_rdata);
        chk("pump_on", 8'h00, {7'h00, pump_on});
        wr_ctrl(8'h46);
        chk("ctrl_rdata", 8'h80, ctrl_rdata);
        low_voltage_pin = 1'b0;
        wait_lvi(1'b0);
        chk("ctrl_rdata", 8'h00, ctrl_rdata);
        $display("t_inhibit done");
    endtask

    initial begin
        mclk            = 1'b0;
        rc_clk          = 1'b0;
        rst             = 1'b1;
        low_voltage_pin = 1'b0;
        ctrl_wr         = 1'b0;
        ctrl_wdata      = 8'h00;
        acc             = '0;
        mismatches      = 0;
        n_tests         = 0;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        t_reset();
        t_power_gate();
        t_program();
        t_erase();
        t_rc();
        t_inhibit();
        final_report();
    end
endmodule
